// ==== src/pps_time_tag_gen.sv ====
// Once-per-second strobe and matching ASCII time tag on a chosen serial port.
// Assumes time fields and fix data come from receiver logic on clk_sys.
`timescale 1ns/1ps
module pps_time_tag_gen
  import pps_pkg::*;
#(
  parameter int SEC_CYC_P   = SEC_CYC,
  parameter int PULSE_CYC_P = PULSE_CYC,
  parameter int LEAD_CYC_P  = LEAD_CYC,
  parameter int BIT_CYC_P   = BIT_CYC,
  parameter int DEPTH       = FIFO_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       sec_align,
  input  wire logic       port_sel,
  input  wire logic [6:0] utc_year,
  input  wire logic [6:0] utc_month,
  input  wire logic [6:0] utc_day,
  input  wire logic [6:0] utc_hour,
  input  wire logic [6:0] utc_min,
  input  wire logic [6:0] utc_sec,
  input  wire logic [2:0] fix_type,
  input  wire logic [3:0] sat_count,
  output logic            second_strobe_out_a,
  output logic            second_strobe_out_b,
  output logic            txd_a,
  output logic            txd_b
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             strobe_a;
    logic             strobe_b;
    tag_st_t          st;
    logic [4:0]       idx;
    logic [6:0]       yy;
    logic [6:0]       mo;
    logic [6:0]       dd;
    logic [6:0]       hh;
    logic [6:0]       mi;
    logic [6:0]       ss;
    logic [2:0]       fix;
    logic [3:0]       sat;
    logic             txd_a;
    logic             txd_b;
  } top_st_t;

  top_st_t    st_ff, nxt_st;
  logic [7:0] tag_ch;
  logic       push;
  logic       fifo_ready;
  logic       utx_valid;
  logic       utx_ready;
  logic [7:0] utx_data;
  logic       utx_txd;

  localparam logic [CNT_W-1:0] CNT_LAST  = CNT_W'(SEC_CYC_P - 1);
  localparam logic [CNT_W-1:0] CNT_PULSE = CNT_W'(PULSE_CYC_P);
  localparam logic [CNT_W-1:0] CNT_TAG   = CNT_W'(SEC_CYC_P - LEAD_CYC_P);

  ////////////////////////////////////////////////////////////////////////////
  // Character helpers

  // One decimal digit of a two-digit field, clamped so it never overflows
  function automatic logic [7:0] dig(input logic [6:0] v, input logic tens);
    logic [6:0] c;
    c = (v > 7'd99) ? 7'd99 : v;
    if (tens) begin
      dig = CH_ZERO + 8'(c / 7'd10);
    end else begin
      dig = CH_ZERO + 8'(c % 7'd10);
    end
  endfunction : dig

  // Fix character; no tracking or an unused code falls back to '?'
  function automatic logic [7:0] fix_char(input logic [2:0] f, input logic [3:0] n);
    fix_char = CH_QM;
    if (n != 4'd0) begin
      case (f)
        3'd1, 3'd2, 3'd4, 3'd5: fix_char = CH_ZERO + 8'(f);
        default:                fix_char = CH_QM;
      endcase
    end
  endfunction : fix_char

  // Count above nine saturates, since only one digit fits the slot
  function automatic logic [7:0] sat_char(input logic [3:0] n);
    if (n == 4'd0) begin
      sat_char = CH_QM;
    end else if (n > 4'd9) begin
      sat_char = CH_NINE;
    end else begin
      sat_char = CH_ZERO + 8'(n);
    end
  endfunction : sat_char

  ////////////////////////////////////////////////////////////////////////////
  // Tag character selection by position

  always_comb begin
    case (st_ff.idx)
      5'd0:               tag_ch = CH_U;
      5'd1:               tag_ch = CH_T;
      5'd2:               tag_ch = CH_C;
      5'd3, 5'd12, 5'd21: tag_ch = CH_SP;
      5'd4:               tag_ch = dig(st_ff.yy, 1'b1);
      5'd5:               tag_ch = dig(st_ff.yy, 1'b0);
      5'd6, 5'd9:         tag_ch = CH_DOT;
      5'd7:               tag_ch = dig(st_ff.mo, 1'b1);
      5'd8:               tag_ch = dig(st_ff.mo, 1'b0);
      5'd10:              tag_ch = dig(st_ff.dd, 1'b1);
      5'd11:              tag_ch = dig(st_ff.dd, 1'b0);
      5'd13:              tag_ch = dig(st_ff.hh, 1'b1);
      5'd14:              tag_ch = dig(st_ff.hh, 1'b0);
      5'd15, 5'd18:       tag_ch = CH_COLON;
      5'd16:              tag_ch = dig(st_ff.mi, 1'b1);
      5'd17:              tag_ch = dig(st_ff.mi, 1'b0);
      5'd19:              tag_ch = dig(st_ff.ss, 1'b1);
      5'd20:              tag_ch = dig(st_ff.ss, 1'b0);
      5'd22:              tag_ch = fix_char(st_ff.fix, st_ff.sat);
      5'd23:              tag_ch = sat_char(st_ff.sat);
      5'd24:              tag_ch = CH_CR;
      5'd25:              tag_ch = CH_LF;
      default:            tag_ch = CH_SP;
    endcase
  end

  // Characters go out only as the FIFO accepts them, so a slow line stalls here
  assign push = (st_ff.st == ST_SEND) && fifo_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = st_ff;
    // Second counter; resolution is one 50 ns cycle, the fastest this clock gives
    if (sec_align || st_ff.cnt == CNT_LAST) begin
      nxt_st.cnt = '0;
    end else begin
      nxt_st.cnt = st_ff.cnt + CNT_W'(1);
    end
    // High for the pulse window from count zero, so the leading edge rises
    nxt_st.strobe_a = (nxt_st.cnt < CNT_PULSE);
    nxt_st.strobe_b = (nxt_st.cnt < CNT_PULSE);
    // Tag start half a second ahead; an unfinished tag is not restarted
    unique case (st_ff.st)
      ST_IDLE: begin
        if (st_ff.cnt == CNT_TAG) begin
          nxt_st.st  = ST_SEND;
          nxt_st.idx = 5'd0;
          nxt_st.yy  = utc_year;
          nxt_st.mo  = utc_month;
          nxt_st.dd  = utc_day;
          nxt_st.hh  = utc_hour;
          nxt_st.mi  = utc_min;
          nxt_st.ss  = utc_sec;
          nxt_st.fix = fix_type;
          nxt_st.sat = sat_count;
        end
      end
      ST_SEND: begin
        if (push) begin
          if (st_ff.idx == 5'(TAG_LEN - 1)) begin
            nxt_st.st  = ST_IDLE;
            nxt_st.idx = 5'd0;
          end else begin
            nxt_st.idx = st_ff.idx + 5'd1;
          end
        end
      end
    endcase
    // Unselected port idles high
    nxt_st.txd_a = port_sel ? 1'b1 : utx_txd;
    nxt_st.txd_b = port_sel ? utx_txd : 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff       <= '0;
      st_ff.st    <= ST_IDLE;
      st_ff.txd_a <= 1'b1;
      st_ff.txd_b <= 1'b1;
      // Parked on the last count so the first enabled edge opens a whole second
      st_ff.cnt   <= CNT_LAST;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign second_strobe_out_a = st_ff.strobe_a;
  assign second_strobe_out_b = st_ff.strobe_b;
  assign txd_a               = st_ff.txd_a;
  assign txd_b               = st_ff.txd_b;

  ////////////////////////////////////////////////////////////////////////////
  // Character buffer and serial line

  tag_fifo #(
    .W     (8),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clk_en    (clk_en),
    .in_valid  (st_ff.st == ST_SEND),
    .in_ready  (fifo_ready),
    .in_data   (tag_ch),
    .out_valid (utx_valid),
    .out_ready (utx_ready),
    .out_data  (utx_data)
  );

  tag_uart_tx #(
    .BIT_CYC_P (BIT_CYC_P)
  ) u_utx (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clk_en   (clk_en),
    .in_valid (utx_valid),
    .in_ready (utx_ready),
    .in_data  (utx_data),
    .txd      (utx_txd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_STROBE_RISE: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(second_strobe_out_a) |-> st_ff.cnt == '0) else $error("strobe rose off second");

  AST_STROBE_LOW_BEFORE: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && st_ff.cnt == CNT_LAST && !sec_align |=> $rose(second_strobe_out_a))
    else $error("no rising edge at second");

  AST_STROBE_WIDTH: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(second_strobe_out_a) |-> st_ff.cnt == CNT_PULSE) else $error("strobe width wrong");

  AST_BOTH_PINS: assert property (@(posedge clk_sys) disable iff (rst)
    second_strobe_out_a == second_strobe_out_b) else $error("strobe pins differ");

  AST_TAG_START: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && st_ff.st == ST_IDLE && st_ff.cnt == CNT_TAG |=> st_ff.st == ST_SEND)
    else $error("tag not started half second early");

  AST_ASCII: assert property (@(posedge clk_sys) disable iff (rst)
    push |-> !tag_ch[7] && tag_ch >= CH_LF) else $error("non-text character");

  AST_FIX: assert property (@(posedge clk_sys) disable iff (rst)
    push && st_ff.idx == 5'(POS_FIX) |-> tag_ch != 8'h33) else $error("fix code 3 sent");

  AST_SAT: assert property (@(posedge clk_sys) disable iff (rst)
    push && st_ff.idx == 5'(POS_SAT) |-> tag_ch == CH_QM ||
      (tag_ch > CH_ZERO && tag_ch <= CH_NINE)) else $error("bad count character");

  AST_EOL: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && push && st_ff.idx == 5'(POS_CR) |-> tag_ch == CH_CR ##1
      (st_ff.idx == 5'(POS_LF) && tag_ch == CH_LF)) else $error("bad line end");

  AST_QMARK: assert property (@(posedge clk_sys) disable iff (rst)
    push && st_ff.sat == 4'd0 && st_ff.idx == 5'(POS_FIX) |-> tag_ch == CH_QM)
    else $error("no question mark without satellites");

  AST_DIGITS: assert property (@(posedge clk_sys) disable iff (rst)
    push && (st_ff.idx inside {5'd4, 5'd5, 5'd7, 5'd8, 5'd10, 5'd11,
                               5'd13, 5'd14, 5'd16, 5'd17, 5'd19, 5'd20}) |->
      tag_ch >= CH_ZERO && tag_ch <= CH_NINE) else $error("field not a digit");

  AST_SEPARATORS: assert property (@(posedge clk_sys) disable iff (rst)
    push && (st_ff.idx inside {5'd3, 5'd12, 5'd21}) |-> tag_ch == CH_SP)
    else $error("separator not a space");

  AST_PUNCT: assert property (@(posedge clk_sys) disable iff (rst)
    push && (st_ff.idx inside {5'd6, 5'd9, 5'd15, 5'd18}) |->
      tag_ch == ((st_ff.idx < 5'd12) ? CH_DOT : CH_COLON))
    else $error("bad date or time mark");

  AST_TAG_DONE: assert property (@(posedge clk_sys) disable iff (rst)
    st_ff.cnt == CNT_LAST |-> st_ff.st == ST_IDLE && !utx_valid)
    else $error("tag still queued at the second");

  AST_TAG_LATCH: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && st_ff.st == ST_IDLE && st_ff.cnt == CNT_TAG |=>
      st_ff.hh == $past(utc_hour) && st_ff.ss == $past(utc_sec)) else $error("time not latched");

endmodule : pps_time_tag_gen

// ==== src/pps_pkg.sv ====
// Constants shared by the second strobe and time tag generator.
// Assumes a single 20 MHz system clock feeding every module.
package pps_pkg;

  // Clock and timing figures, each in its own unit
  localparam int CLK_PERIOD_NS = 50;
  localparam int SEC_NS        = 1_000_000_000;
  localparam int PULSE_NS      = 1_000_000;
  localparam int LEAD_NS       = 500_000_000;
  localparam int SEC_CYC       = SEC_NS / CLK_PERIOD_NS;
  localparam int PULSE_CYC     = PULSE_NS / CLK_PERIOD_NS;
  localparam int LEAD_CYC      = LEAD_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 25;

  // Serial line, 8N1
  localparam int BAUD_DEF      = 9600;
  localparam int BIT_CYC       = SEC_NS / (CLK_PERIOD_NS * BAUD_DEF);
  localparam int FIFO_DEPTH    = 4;

  // Tag layout: "UTC yy.mm.dd hh:mm:ss ab" CR LF
  localparam int TAG_LEN       = 26;
  localparam int POS_FIX       = 22;
  localparam int POS_SAT       = 23;
  localparam int POS_CR        = 24;
  localparam int POS_LF        = 25;

  // ASCII codes
  localparam logic [7:0] CH_U     = 8'h55;
  localparam logic [7:0] CH_T     = 8'h54;
  localparam logic [7:0] CH_C     = 8'h43;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_DOT   = 8'h2e;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_QM    = 8'h3f;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;

  typedef enum logic {ST_IDLE, ST_SEND} tag_st_t;

endpackage : pps_pkg

// ==== src/tag_fifo.sv ====
// Small synchronous FIFO holding tag characters on their way to the line.
// Assumes producer and consumer share clk_sys; read data is the head word.
`timescale 1ns/1ps
module tag_fifo
  import pps_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } fifo_st_t;

  fifo_st_t st_ff, nxt_st;
  logic     push, pop;

  // Honest flags straight from the occupancy count
  assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data  = st_ff.mem[st_ff.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer wrap relies on DEPTH being a power of two
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr] = in_data;
      nxt_st.wr            = st_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd = st_ff.rd + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk_sys) disable iff (rst)
    st_ff.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule : tag_fifo

// ==== src/tag_uart_tx.sv ====
// Serial transmitter, 8 data bits, no parity, one stop bit, LSB first.
// Assumes a character is offered with valid and held until ready.
`timescale 1ns/1ps
module tag_uart_tx
  import pps_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            txd
);
  typedef struct packed {
    logic        busy;
    logic [9:0]  shift;
    logic [3:0]  nbits;
    logic [15:0] baud;
    logic        txd;
  } utx_st_t;

  utx_st_t st_ff, nxt_st;

  assign in_ready = !st_ff.busy;
  assign txd      = st_ff.txd;

  // Load a frame, then shift one bit per bit time; line idles high
  always_comb begin
    nxt_st = st_ff;
    if (!st_ff.busy) begin
      nxt_st.txd = 1'b1;
      if (in_valid) begin
        nxt_st.busy  = 1'b1;
        nxt_st.shift = {1'b1, in_data, 1'b0};
        nxt_st.nbits = 4'd0;
        nxt_st.baud  = 16'h0000;
      end
    end else begin
      nxt_st.txd = st_ff.shift[0];
      if (st_ff.baud == 16'(BIT_CYC_P - 1)) begin
        nxt_st.baud  = 16'h0000;
        nxt_st.shift = {1'b1, st_ff.shift[9:1]};
        nxt_st.nbits = st_ff.nbits + 4'd1;
        if (st_ff.nbits == 4'd9) begin
          nxt_st.busy = 1'b0;
        end
      end else begin
        nxt_st.baud = st_ff.baud + 16'd1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= '{busy: 1'b0, shift: 10'h3ff, nbits: 4'h0, baud: 16'h0000, txd: 1'b1};
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  AST_UTX_IDLE_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
    !st_ff.busy && !$past(st_ff.busy) |-> txd) else $error("line not idle high");

endmodule : tag_uart_tx

// ==== dv/tag_rx_model.sv ====
// Far-side serial receiver model: rebuilds characters from one tag line.
// Assumes 8N1, LSB first, idle high, BIT_CYC_P clock cycles per bit, clk_sys shared.
`timescale 1ns/1ps
module tag_rx_model #(
  parameter int BIT_CYC_P = 3
) (
  input  wire logic clk_sys,
  input  wire logic rxd,
  output logic [7:0] rx_byte,
  output logic       rx_stb,
  output logic       frame_bad
);
  int i;

  ////////////////////////////////////////////////////////////////////////////////
  // Sample on the falling edge so the registered line has settled; a whole
  // frame is taken before the next start bit is looked for
  initial begin
    rx_byte   = 8'h00;
    rx_stb    = 1'b0;
    frame_bad = 1'b0;
    forever begin
      @(negedge clk_sys);
      rx_stb = 1'b0;
      if (rxd === 1'b0) begin
        // Centre on the start bit, then step one bit time per sample
        repeat (BIT_CYC_P / 2) @(negedge clk_sys);
        for (i = 0; i < 8; i++) begin
          repeat (BIT_CYC_P) @(negedge clk_sys);
          rx_byte[i] = rxd;  // LSB first
        end
        repeat (BIT_CYC_P) @(negedge clk_sys);
        frame_bad = (rxd !== 1'b1);  // A missing stop bit is a framing fault
        rx_stb    = 1'b1;
      end
    end
  end
endmodule : tag_rx_model

// ==== dv/testbench.sv ====
// Self-checking bench for the second strobe and time tag generator.
// Assumes shortened counts; one receiver model listens on each serial port.
`timescale 1ns/1ps
module testbench
  import pps_pkg::*;
;
  localparam int T_SEC  = 2000;
  localparam int T_PUL  = 20;
  localparam int T_LEAD = 1000;
  localparam int T_BIT  = 3;

  logic       clk_sys;
  logic       rst;
  logic       clk_en;
  logic       sec_align;
  logic       port_sel;
  logic [6:0] yr, mo, dy, hr, mi, sc;
  logic [2:0] fix_type;
  logic [3:0] sat_count;
  logic       strobe_a, strobe_b, txd_a, txd_b;
  logic [7:0] byte_a, byte_b;
  logic       stb_a, stb_b, bad_a, bad_b;
  logic [8:0] q_a[$];
  logic [8:0] q_b[$];
  int         error_cnt = 0;
  int         tests_run = 0;
  int         split_cnt = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Device and the two far-side receivers
  pps_time_tag_gen #(
    .SEC_CYC_P   (T_SEC),
    .PULSE_CYC_P (T_PUL),
    .LEAD_CYC_P  (T_LEAD),
    .BIT_CYC_P   (T_BIT)
  ) pps_time_tag_gen_inst (
    .clk_sys (clk_sys), .rst (rst), .clk_en (clk_en), .sec_align (sec_align),
    .port_sel (port_sel), .utc_year (yr), .utc_month (mo), .utc_day (dy),
    .utc_hour (hr), .utc_min (mi), .utc_sec (sc), .fix_type (fix_type),
    .sat_count (sat_count), .second_strobe_out_a (strobe_a),
    .second_strobe_out_b (strobe_b), .txd_a (txd_a), .txd_b (txd_b)
  );
  tag_rx_model #(.BIT_CYC_P(T_BIT)) rx_a_inst (
    .clk_sys (clk_sys), .rxd (txd_a), .rx_byte (byte_a), .rx_stb (stb_a), .frame_bad (bad_a)
  );
  tag_rx_model #(.BIT_CYC_P(T_BIT)) rx_b_inst (
    .clk_sys (clk_sys), .rxd (txd_b), .rx_byte (byte_b), .rx_stb (stb_b), .frame_bad (bad_b)
  );

  // Clock and character collection; framing fault rides in bit 8
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (stb_a === 1'b1) q_a.push_back({bad_a, byte_a});
    if (stb_b === 1'b1) q_b.push_back({bad_b, byte_b});
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared checking and waiting tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // Bounded wait for a rising strobe; returns at the falling edge after it
  task automatic wait_rise();
    logic p;
    p = strobe_a;
    for (int n = 0; n < 3 * T_SEC; n++) begin
      @(negedge clk_sys);
      if (p === 1'b0 && strobe_a === 1'b1) return;
      p = strobe_a;
    end
    check(32'h0, 32'h1, "no strobe edge");
    tally_and_finish();
  endtask : wait_rise

  // Counts cycles the strobe holds one level; both copies must agree
  task automatic count_level(input logic v, output int n);
    n = 0;
    while (strobe_a === v && n < 3 * T_SEC) begin
      if (strobe_b !== strobe_a) split_cnt++;
      n++;
      @(negedge clk_sys);
    end
  endtask : count_level

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_strobe();
    int n;
    wait_rise();
    count_level(1'b1, n);
    check(n, T_PUL, "pulse width");
    count_level(1'b0, n);
    check(n, T_SEC - T_PUL, "low time");
    count_level(1'b1, n);
    check(n, T_PUL, "next pulse");
    check(split_cnt, 0, "strobe copies differ");
    $display("test_strobe done");
  endtask : test_strobe

  // Alignment mid-second restarts the second at once
  task automatic test_align();
    int n;
    wait_rise();
    repeat (500) @(negedge clk_sys);
    sec_align = 1'b1;
    @(negedge clk_sys);
    sec_align = 1'b0;
    check(strobe_a, 1'b1, "strobe after align");
    count_level(1'b1, n);
    check(n, T_PUL, "aligned width");
    count_level(1'b0, n);
    check(n, T_SEC - T_PUL, "aligned period");
    // Enable low freezes the count, so the pulse resumes where it stopped
    clk_en = 1'b0;
    repeat (100) @(negedge clk_sys);
    check({strobe_a, txd_a, txd_b}, 3'h7, "frozen outputs");
    clk_en = 1'b1;
    count_level(1'b1, n);
    check(n, T_PUL, "width across freeze");
    $display("test_align done");
  endtask : test_align

  // One tag: nothing before the lead point, full tag before the next strobe
  task automatic run_tag(input int ty, tm, td, th, tn, ts, input logic [2:0] f,
                         input logic [3:0] cnt, input logic sel, input byte fa, sb);
    string      s;
    logic [8:0] got[$];
    int         n;
    wait_rise();
    yr = ty[6:0];
    mo = tm[6:0];
    dy = td[6:0];
    hr = th[6:0];
    mi = tn[6:0];
    sc = ts[6:0];
    fix_type = f;
    sat_count = cnt;
    port_sel = sel;
    q_a.delete();
    q_b.delete();
    repeat (T_SEC - T_LEAD - 5) @(negedge clk_sys);
    check(q_a.size() + q_b.size(), 0, "early tag");
    check({txd_a, txd_b}, 2'h3, "lines idle before tag");
    // The start bit may not lead the lead point, and must follow it closely
    n = 0;
    while ((sel ? txd_b : txd_a) === 1'b1 && n < 20) begin
      n++;
      @(negedge clk_sys);
    end
    check(n >= 5 && n < 20, 1'b1, "tag start near lead point");
    wait_rise();
    s = $sformatf("UTC %02d.%02d.%02d %02d:%02d:%02d %c%c%c%c", ty, tm, td, th, tn, ts,
                  fa, sb, CH_CR, CH_LF);
    if (sel) begin
      got = q_b;
      check(q_a.size(), 0, "tag on port a");
    end else begin
      got = q_a;
      check(q_b.size(), 0, "tag on port b");
    end
    check(got.size(), TAG_LEN, "tag length");
    for (int i = 0; i < s.len() && i < got.size(); i++) begin
      check(got[i], {1'b0, s[i]}, "tag char");
    end
    $display("run_tag done");
  endtask : run_tag

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence, with a watchdog that cuts a hang short
  initial begin
    repeat (100000) @(posedge clk_sys);
    check(32'h0, 32'h1, "watchdog");
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    sec_align = 1'b0;
    port_sel = 1'b0;
    {yr, mo, dy, hr, mi, sc} = '0;
    fix_type = 3'h5;
    sat_count = 4'h6;
    repeat (20) @(negedge clk_sys);
    check(strobe_a, 1'b0, "strobe in reset");
    check({txd_a, txd_b}, 2'h3, "lines idle in reset");
    rst = 1'b0;
    test_strobe();
    run_tag(93, 12, 21, 20, 21, 16, 3'h5, 4'h6, 1'b0, 8'h35, 8'h36);
    run_tag(5, 1, 2, 0, 9, 0, 3'h1, 4'h9, 1'b1, 8'h31, 8'h39);
    run_tag(99, 6, 30, 23, 59, 59, 3'h2, 4'h1, 1'b0, 8'h32, 8'h31);
    run_tag(0, 1, 1, 12, 0, 0, 3'h4, 4'h3, 1'b1, 8'h34, 8'h33);
    run_tag(0, 1, 1, 12, 0, 1, 3'h3, 4'h5, 1'b0, CH_QM, 8'h35);
    run_tag(0, 1, 1, 12, 0, 2, 3'h5, 4'h0, 1'b0, CH_QM, CH_QM);
    run_tag(0, 1, 1, 12, 0, 3, 3'h5, 4'hc, 1'b0, 8'h35, 8'h39);
    test_align();
    tally_and_finish();
  end
endmodule : testbench
